// ===== sram_boundary_scan_tap.sv
// Operation
// - five tms-high edges reset port, memory undisturbed
// - tms, tdi and pin levels sampled on tck rising edge; core data and enable on clk
// - tdo changes on falling edge, floats unless shifting
// - tms and tdi used as driven, no pull-up, open reads z
// - data enters at msb, leaves at lsb
// - port reset from system reset at power-up, tdo floating
// - three-bit instruction register shifted in shift-ir
// - instruction takes effect only at update-ir or test-logic-reset
// - reset and test-logic-reset load idcode instruction
// - instruction capture loads 01 into low bits
// - instruction selects exactly one data register
// - one-bit bypass register cleared under bypass
// - boundary register captures pins, then shifts them
// - idcode captures fixed 32-bit value, shifts out
// - all eight codes decoded, three reserved unused
// - sample z floats output bus until next update-ir or test-logic-reset
// - sample/preload snapshots all pins at capture
// - bypass places bypass register in data path
// - extest drives preloaded cells onto output pins
// - tri-state cell defaults high at reset states
`timescale 1ns/1ns
`default_nettype none

module sram_boundary_scan_tap (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoOeN,
  input wire logic [sbst_pkg::PIN_W-1:0] memIn,
  input wire logic [sbst_pkg::PIN_W-1:0] coreData,
  input wire logic coreOutEn,
  output logic [sbst_pkg::PIN_W-1:0] busOut,
  output logic busOutOeN
);
  import sbst_pkg::*;

  // ****************************************
  // functions
  // ****************************************

  // next controller state from the sampled tms level
  function automatic sbst_state_type tapNext(input sbst_state_type s, input logic m);
    sbst_state_type n;
    n = ST_TLR;
    unique case (s)
      ST_TLR: n = m ? ST_TLR : ST_RTI;
      ST_RTI: n = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: n = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: n = m ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: n = m ? ST_SEL_DR : ST_RTI;
    endcase
    return n;
  endfunction : tapNext

  // data register chosen by an instruction; reserved codes go to bypass
  function automatic sbst_dr_type drSelect(input logic [IR_W-1:0] ir);
    sbst_dr_type d;
    d = DR_BYPASS;
    unique case (ir)
      IR_IDCODE: d = DR_ID;
      IR_EXTEST, IR_SAMPLEZ, IR_SAMPLE: d = DR_BSR;
      default: d = DR_BYPASS;
    endcase
    return d;
  endfunction : drSelect

  // ****************************************
  // port reset from the memory clock
  // ****************************************

  logic tapRstReg; // power-up reset of the test-clock logic

  // held while the system reset is high; clears the port with tck idle
  always_ff @(posedge clk) begin
    tapRstReg <= sys_rst;
  end

  // ****************************************
  // test-clock domain: controller and registers
  // ****************************************

  sbst_state_type stateReg; // controller state
  sbst_state_type stateNext; // state after this edge
  logic [IR_W-1:0] irShift; // instruction shift stage
  logic [IR_W-1:0] irReg; // active instruction
  logic [ID_W-1:0] idShift; // identification shift stage
  logic [BSR_W-1:0] bsrShift; // boundary shift stage
  logic [BSR_W-1:0] bsrUpd; // boundary update (preload) stage
  logic bypassReg; // single bypass flip-flop
  logic [BSR_W-1:0] pinMeta; // pin synchroniser, first stage
  logic [BSR_W-1:0] pinSync; // pin synchroniser, second stage
  logic pubReg; // publish settings on next edge
  sbst_xfer_type xferReg; // settings held for the memory clock
  logic xferTgl; // flips once per published setting
  logic tdoReg; // serial output flop
  logic tdoOeNReg; // serial output enable, low drives

  // decoded controller conditions
  wire sbst_dr_type drSel = drSelect(irReg);
  wire shiftIr = (stateReg == ST_SHIFT_IR);
  wire shiftDr = (stateReg == ST_SHIFT_DR);
  wire capDr = (stateReg == ST_CAP_DR);
  wire enterTlr = (stateNext == ST_TLR) && (stateReg != ST_TLR);
  wire pubNext = (stateReg == ST_UPD_IR) || (stateReg == ST_UPD_DR) || enterTlr;
  // tms and tdi taken straight from the pads; no pull-up is modelled, so undriven lines read z
  wire tmsIn = tms;
  wire tdiIn = tdi;
  // bit handed to tdo: lsb of the register in the path
  wire tdoBit = shiftIr ? irShift[0] :
                (drSel == DR_ID) ? idShift[0] :
                (drSel == DR_BSR) ? bsrShift[0] : bypassReg;
  wire tdoEnNext = shiftIr || shiftDr;
  // settings that the memory clock takes over
  // in test-logic-reset the instruction and tri-state cell reload on this same edge,
  // so hand over the reset settings, not the stale instruction
  wire inTlr = (stateReg == ST_TLR);
  wire sbst_xfer_type xferNext = inTlr ?
    sbst_xfer_type'{1'b0, 1'b0, bsrUpd[BSR_OUT_LSB +: PIN_W], TRI_CELL_RESET} :
    sbst_xfer_type'{(irReg == IR_EXTEST), (irReg == IR_SAMPLEZ),
                    bsrUpd[BSR_OUT_LSB +: PIN_W], bsrUpd[BSR_TRI_POS]};

  assign stateNext = tapNext(stateReg, tmsIn);

  // controller state, advanced on each rising tck edge
  always_ff @(posedge tck or posedge tapRstReg) begin
    if (tapRstReg) begin
      stateReg <= ST_TLR;
    end else begin
      stateReg <= stateNext;
    end
  end

  // instruction register: shift stage and active stage
  always_ff @(posedge tck or posedge tapRstReg) begin
    if (tapRstReg) begin
      irShift <= IR_RESET;
      irReg <= IR_RESET;
    end else begin
      // capture loads the fixed check pattern
      if (stateReg == ST_CAP_IR) begin
        irShift <= {IR_CAPTURE_TOP, IR_CAPTURE_PAT};
      end else if (shiftIr) begin
        irShift <= {tdiIn, irShift[IR_W-1:1]};
      end
      // active instruction changes only at update or reset
      if (stateReg == ST_TLR) begin
        irReg <= IR_RESET;
      end else if (stateReg == ST_UPD_IR) begin
        irReg <= irShift;
      end
    end
  end

  // data registers: capture and shift of the selected one
  always_ff @(posedge tck or posedge tapRstReg) begin
    if (tapRstReg) begin
      idShift <= ID_VALUE;
      bsrShift <= '0;
      bypassReg <= BYPASS_CAPTURE;
    end else if (capDr) begin
      // only the selected register captures
      if (drSel == DR_ID) begin
        idShift <= ID_VALUE;
      end else if (drSel == DR_BSR) begin
        bsrShift <= pinSync;
      end else begin
        bypassReg <= BYPASS_CAPTURE;
      end
    end else if (shiftDr) begin
      // serial entry at msb, exit at lsb
      if (drSel == DR_ID) begin
        idShift <= {tdiIn, idShift[ID_W-1:1]};
      end else if (drSel == DR_BSR) begin
        bsrShift <= {tdiIn, bsrShift[BSR_W-1:1]};
      end else begin
        bypassReg <= tdiIn;
      end
    end
  end

  // boundary update stage; tri-state cell forced high in reset
  always_ff @(posedge tck or posedge tapRstReg) begin
    if (tapRstReg) begin
      bsrUpd <= '0;
      bsrUpd[BSR_TRI_POS] <= TRI_CELL_RESET;
    end else if (stateReg == ST_TLR) begin
      bsrUpd[BSR_TRI_POS] <= TRI_CELL_RESET;
    end else if ((stateReg == ST_UPD_DR) && (drSel == DR_BSR)) begin
      bsrUpd <= bsrShift;
    end
  end

  // pin levels come from the memory clock: two flops before use
  always_ff @(posedge tck or posedge tapRstReg) begin
    if (tapRstReg) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= {~busOutOeN, busOut, memIn};
      pinSync <= pinMeta;
    end
  end

  // publish settings one edge after an update or entry to test-logic-reset, with a toggle
  always_ff @(posedge tck or posedge tapRstReg) begin
    if (tapRstReg) begin
      pubReg <= 1'b0;
      xferReg <= XFER_RESET;
      xferTgl <= 1'b0;
    end else begin
      pubReg <= pubNext;
      if (pubReg) begin
        xferReg <= xferNext;
        xferTgl <= ~xferTgl;
      end
    end
  end

  // serial output moves on the falling edge only
  always_ff @(negedge tck or posedge tapRstReg) begin
    if (tapRstReg) begin
      tdoReg <= 1'b0;
      tdoOeNReg <= 1'b1;
    end else begin
      tdoReg <= tdoBit;
      tdoOeNReg <= ~tdoEnNext;
    end
  end

  assign tdo = tdoReg;
  assign tdoOeN = tdoOeNReg;

  // ****************************************
  // memory-clock domain: output bus control
  // ****************************************

  logic tglMeta; // toggle synchroniser, first stage
  logic tglSync; // toggle synchroniser, second stage
  logic tglSeen; // last toggle level acted on
  sbst_xfer_type curXfer; // settings in force at the pins
  logic [PIN_W-1:0] busOutReg; // output bus data
  logic busOutOeNReg; // output bus enable, low drives

  // new settings arrive when the toggle changes
  wire xferArrive = (tglSync != tglSeen);
  // extest drives the preloaded cells, gated by the tri-state cell
  wire [PIN_W-1:0] busOutNext = curXfer.extest ? curXfer.outVal : coreData;
  wire busOeNNext = curXfer.floatOut ? 1'b1 :
                    curXfer.extest ? ~curXfer.outEn : ~coreOutEn;

  // toggle crossing; held data is stable long before the toggle lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tglMeta <= 1'b0;
      tglSync <= 1'b0;
      tglSeen <= 1'b0;
      curXfer <= XFER_RESET;
    end else begin
      tglMeta <= xferTgl;
      tglSync <= tglMeta;
      tglSeen <= tglSync;
      if (xferArrive) begin
        curXfer <= xferReg;
      end
    end
  end

  // output bus; the port never disturbs normal reads otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busOutReg <= '0;
      busOutOeNReg <= 1'b1;
    end else begin
      busOutReg <= busOutNext;
      busOutOeNReg <= busOeNNext;
    end
  end

  assign busOut = busOutReg;
  assign busOutOeN = busOutOeNReg;

  // ****************************************
  // assertions
  // ****************************************

  sequence tmsHeldFive;
    tmsIn [*5];
  endsequence

  sequence irCapture;
    stateReg == ST_CAP_IR;
  endsequence

  a_five_tms_reset: assert property (@(posedge tck) disable iff (tapRstReg)
    tmsHeldFive |=> (stateReg == ST_TLR))
    else $error("five tms-high edges did not reach reset");

  a_ir_capture_pat: assert property (@(posedge tck) disable iff (tapRstReg)
    irCapture |=> (irShift[1:0] == IR_CAPTURE_PAT))
    else $error("instruction capture pattern wrong");

  a_ir_held_stable: assert property (@(posedge tck) disable iff (tapRstReg)
    (stateReg != ST_UPD_IR) && (stateReg != ST_TLR) |=> $stable(irReg))
    else $error("instruction changed outside update");

  a_tlr_loads_id: assert property (@(posedge tck) disable iff (tapRstReg)
    (stateReg == ST_TLR) |=> (irReg == IR_IDCODE) && bsrUpd[BSR_TRI_POS])
    else $error("reset state did not load idcode");

  a_bypass_cleared: assert property (@(posedge tck) disable iff (tapRstReg)
    capDr && (irReg == IR_BYPASS) |=> !bypassReg)
    else $error("bypass not cleared at capture");

  a_bypass_path: assert property (@(posedge tck) disable iff (tapRstReg)
    shiftDr && (drSel == DR_BYPASS) |=> (bypassReg == $past(tdiIn)))
    else $error("bypass did not take tdi");

  a_id_capture: assert property (@(posedge tck) disable iff (tapRstReg)
    capDr && (irReg == IR_IDCODE) |=> (idShift == ID_VALUE))
    else $error("identification value not captured");

  a_bsr_capture: assert property (@(posedge tck) disable iff (tapRstReg)
    capDr && (drSel == DR_BSR) |=> (bsrShift == $past(pinSync)))
    else $error("boundary register missed pin values");

  a_tdo_float: assert property (@(posedge tck) disable iff (tapRstReg)
    (shiftIr || shiftDr) == !tdoOeNReg)
    else $error("tdo enable does not follow shift states");

  a_samplez_float: assert property (@(posedge clk) disable iff (sys_rst)
    curXfer.floatOut |=> busOutOeNReg)
    else $error("output bus driven under sample z");

endmodule : sram_boundary_scan_tap

`default_nettype wire

// ===== sbst_pkg.sv
// ****************************************
// shared constants and types of the test port
// ****************************************
package sbst_pkg;

  // instruction register width and codes
  localparam int IR_W = 3;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPLEZ = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  // instruction loaded at power-up and in test-logic-reset
  localparam logic [2:0] IR_RESET = IR_IDCODE;
  // pattern put into the two low bits at instruction capture
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  // fill of the top instruction bit at capture
  localparam logic IR_CAPTURE_TOP = 1'b0;

  // identification register; the value is arbitrary, lsb set as usual
  localparam int ID_W = 32;
  localparam logic [31:0] ID_VALUE = 32'h0A5C_3E01;

  // boundary register layout: inputs, outputs, tri-state cell
  localparam int PIN_W = 8;
  localparam int BSR_W = 17;
  localparam int BSR_IN_LSB = 0;
  localparam int BSR_OUT_LSB = 8;
  localparam int BSR_TRI_POS = 16;
  // tri-state cell default enables the output bus
  localparam logic TRI_CELL_RESET = 1'b1;
  // bypass register value at capture
  localparam logic BYPASS_CAPTURE = 1'b0;

  // test clock limit, to be kept by the controller
  localparam int TCK_MIN_PERIOD_NS = 50;
  // edges of tms high that always reach test-logic-reset
  localparam int TMS_RESET_EDGES = 5;

  // controller states
  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SHIFT_DR = 4'h4,
    ST_EXIT1_DR = 4'h5,
    ST_PAUSE_DR = 4'h6,
    ST_EXIT2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'hA,
    ST_SHIFT_IR = 4'hB,
    ST_EXIT1_IR = 4'hC,
    ST_PAUSE_IR = 4'hD,
    ST_EXIT2_IR = 4'hE,
    ST_UPD_IR = 4'hF
  } sbst_state_type;

  // data register chosen by the instruction
  typedef enum logic [1:0] {
    DR_BYPASS = 2'h0,
    DR_ID = 2'h1,
    DR_BSR = 2'h2
  } sbst_dr_type;

  // settings handed from the test clock to the memory clock
  typedef struct packed {
    logic extest;
    logic floatOut;
    logic [PIN_W-1:0] outVal;
    logic outEn;
  } sbst_xfer_type;

  localparam sbst_xfer_type XFER_RESET = '{1'b0, 1'b0, 8'h00, TRI_CELL_RESET};

endpackage : sbst_pkg

// ===== sbst_jtag_host.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// test controller model, tck runs only within frames
// ****************************************
module sbst_jtag_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdoOeN
);
  int glitches; // tdo moved while tck high
  int oeMiss; // tdo floating in a shift bit
  logic oeRise; // tdo enable seen at the last rise

  // idle: clock parked low, released lines at pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    glitches = 0;
    oeMiss = 0;
  end

  // one 64 ns period, lines set while low, tdo taken at the rise
  task step(input logic m, input logic d, output logic o);
    logic seen;
    tms = m;
    tdi = d;
    #32 tck = 1'b1;
    o = tdo;
    seen = tdo;
    oeRise = tdoOeN;
    #31;
    if (seen !== tdo) glitches++;
    #1 tck = 1'b0;
  endtask : step

  // run-test-idle, capture, shift n bits, update, back to idle
  task shift(input logic isIr, input int n, input logic [31:0] din,
             output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o); // select data column
    if (isIr) step(1'b1, 1'b1, o); // select instruction column
    step(1'b0, 1'b1, o); // capture
    step(1'b0, 1'b1, o); // enter shift
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      if (oeRise !== 1'b0) oeMiss++;
      dout[i] = o; // lsb leaves first
    end
    step(1'b1, 1'b1, o); // update
    step(1'b0, 1'b1, o); // run-test-idle, instruction takes effect
    step(1'b0, 1'b1, o); // idle edge hands the settings over
    tms = 1'b1; // released
  endtask : shift

  // five edges of tms high from any state, then park in idle
  task reset5;
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    tms = 1'b1;
  endtask : reset5
endmodule : sbst_jtag_host
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// bench for the boundary-scan test port
// ****************************************
module testbench;
  import sbst_pkg::*;
  logic clk, sys_rst, tck, tms, tdi, tdo, tdoOeN;
  logic [7:0] memIn, coreData, busOut; // pin levels, core data, bus
  logic coreOutEn, busOutOeN;
  logic [31:0] got; // last shifted-out value
  int failCount, nCompared;

  sram_boundary_scan_tap u_sram_boundary_scan_tap (
    .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoOeN(tdoOeN), .memIn(memIn), .coreData(coreData),
    .coreOutEn(coreOutEn), .busOut(busOut), .busOutOeN(busOutOeN));
  sbst_jtag_host u_sbst_jtag_host (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN));

  // 20 mhz memory clock
  always #25 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task ir(input logic [2:0] code);
    u_sbst_jtag_host.shift(1'b1, 3, {29'h0, code}, got);
  endtask : ir

  task dr(input int n, input logic [31:0] din);
    u_sbst_jtag_host.shift(1'b0, n, din, got);
    check("tdo idle", tdoOeN, 1'b1);
  endtask : dr

  // pins change on a clk edge, then let the bus settle
  task pins(input logic [7:0] mi, input logic [7:0] cd, input logic ce);
    @(posedge clk);
    memIn <= mi;
    coreData <= cd;
    coreOutEn <= ce;
    settle;
  endtask : pins

  task settle;
    repeat (8) @(posedge clk);
    #5;
  endtask : settle

  // ****************************************
  // scenarios
  // ****************************************
  task tPowerUp;
    check("float at power-up", tdoOeN, 1'b1);
    pins(8'h3C, 8'h96, 1'b1);
    check("core bus", busOut, 8'h96);
    check("core enable", busOutOeN, 1'b0);
    u_sbst_jtag_host.reset5; // park the controller in run-test-idle
    dr(32, 32'hFFFF_FFFF);
    check("id value", got, ID_VALUE);
  endtask : tPowerUp

  task tBypass;
    logic [2:0] codes [4];
    codes = '{3'h3, 3'h5, 3'h6, IR_BYPASS};
    foreach (codes[k]) begin
      ir(codes[k]);
      check("ir capture", got[2:0], {IR_CAPTURE_TOP, IR_CAPTURE_PAT});
      dr(8, 32'hA5);
      check("bypass path", got[7:0], 8'h4A);
    end
  endtask : tBypass

  // reset in mid instruction shift
  task tResetAbort;
    logic o;
    for (int k = 0; k < 4; k++) u_sbst_jtag_host.step(k < 2, 1'b1, o);
    repeat (2) u_sbst_jtag_host.step(1'b0, 1'b0, o);
    u_sbst_jtag_host.reset5;
    dr(32, 32'h0);
    check("id after reset", got, ID_VALUE);
    check("bus undisturbed", busOut, 8'h96);
  endtask : tResetAbort

  task tSample;
    ir(IR_SAMPLE);
    dr(17, 32'h1_5A00);
    check("snapshot", got[16:0], 17'h1_963C);
    settle;
    check("core kept", busOut, 8'h96);
  endtask : tSample

  task tExtest;
    pins(8'h3C, 8'h96, 1'b0);
    ir(IR_EXTEST);
    settle;
    check("extest bus", busOut, 8'h5A);
    check("extest enable", busOutOeN, 1'b0);
    dr(17, 32'h0_C300);
    check("extest capture", got[16:0], 17'h1_5A3C);
    settle;
    check("tri cell low", busOutOeN, 1'b1);
    u_sbst_jtag_host.reset5;
    settle;
    check("core after reset", busOutOeN, 1'b1);
    check("core data after reset", busOut, 8'h96);
    ir(IR_EXTEST);
    settle;
    check("tri cell default", busOutOeN, 1'b0);
    check("preload kept", busOut, 8'hC3);
    u_sbst_jtag_host.reset5;
  endtask : tExtest

  task tSampleZ;
    pins(8'h3C, 8'h96, 1'b1);
    ir(IR_SAMPLEZ);
    settle;
    check("float bus", busOutOeN, 1'b1);
    dr(17, 32'h0);
    check("z capture tri", got[16], 1'b0);
    check("z capture pins", got[7:0], 8'h3C);
    check("z capture bus", got[15:8], 8'h96);
    settle;
    check("float held", busOutOeN, 1'b1);
    ir(IR_BYPASS);
    settle;
    check("float released", busOutOeN, 1'b0);
  endtask : tSampleZ

  // ****************************************
  // run and verdict
  // ****************************************
  task wrapUp;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrapUp

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    memIn = 8'h00;
    coreData = 8'h00;
    coreOutEn = 1'b0;
    failCount = 0;
    nCompared = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    #5;
    tPowerUp;
    tBypass;
    tResetAbort;
    tSample;
    tExtest;
    tSampleZ;
    check("tdo glitches", u_sbst_jtag_host.glitches, 0);
    check("float in shift", u_sbst_jtag_host.oeMiss, 0);
    wrapUp;
  end

  // watchdog against a hang
  initial begin
    #3_000_000;
    failCount++;
    $display("mismatch watchdog expected done seen hang");
    wrapUp;
  end
endmodule : testbench
`default_nettype wire
